// File: src/pm_protect_regs.svh
// Constants for the program memory write protection block.
`ifndef PM_PROTECT_REGS_SVH
`define PM_PROTECT_REGS_SVH
`define PM_ADDR_W       24
`define PM_PAGE_LSB     10
`define PM_PTR_W        8
`define PM_LAST_PAGE    8'h55
`define PM_CFG_RESET    12'h0ff
`endif

// File: src/pm_protect_pkg.sv
// Types for the program memory write protection block.
package pm_protect_pkg;
   typedef struct packed {
      logic       global_read_protect;
      logic       global_write_protect;
      logic       segment_protect_disable;
      logic       segment_boundary_direction;
      logic       last_page_protect;
      logic [7:0] segment_page_pointer;
   } prot_cfg_t;
   typedef enum logic {
      CAPTURE,
      HOLD
   } cap_state_t;
endpackage

// File: src/pm_protect.sv
// Program memory write and erase protection decision logic.
`include "pm_protect_regs.svh"
module pm_protect
   import pm_protect_pkg::*;
#(
   parameter logic [`PM_PTR_W-1:0] LAST_PAGE = `PM_LAST_PAGE
) (
   // Clock and reset.
   input  wire logic                   mclk_i,
   input  wire logic                   rst_i,
   // Configuration word bits, sampled while reset is asserted.
   input  wire prot_cfg_t              cfg_i,
   // Internal write or erase request.
   input  wire logic                   nvm_req_i,
   input  wire logic [`PM_ADDR_W-1:0]  nvm_addr_i,
   // External programmer request.
   input  wire logic                   ext_req_i,
   input  wire logic                   ext_write_i,
   // Decisions.
   output logic                        nvm_grant_o,
   output logic                        nvm_block_o,
   output logic                        ext_grant_o,
   output logic                        ext_block_o,
   output logic                        cfg_valid_o
);

   prot_cfg_t  cfg_q, cfg_d;
   cap_state_t st_q, st_d;
   logic       nvm_grant_d, nvm_block_d, ext_grant_d, ext_block_d;
   logic       seg_hit, glob_blk;
   logic [`PM_PTR_W-1:0] page;

   // Settings are taken only while reset holds, so a configuration change at run time cannot open a hole.
   always_comb begin
      cfg_d = cfg_q;
      st_d  = st_q;
      if (rst_i) begin
         cfg_d = cfg_i;
         st_d  = CAPTURE;
      end else begin
         st_d = HOLD;
      end
   end

   always_ff @(posedge mclk_i) begin
      cfg_q <= cfg_d;
      st_q  <= st_d;
   end

   // Pages above the last implemented page are treated as part of it.
   function automatic logic [`PM_PTR_W-1:0] page_of(input logic [`PM_ADDR_W-1:0] a);
      logic [`PM_ADDR_W-`PM_PAGE_LSB-1:0] p;
      p = a[`PM_ADDR_W-1:`PM_PAGE_LSB];
      page_of = (p > {{(`PM_ADDR_W-`PM_PAGE_LSB-`PM_PTR_W){1'b0}}, LAST_PAGE}) ? LAST_PAGE : p[`PM_PTR_W-1:0];
   endfunction

   always_comb begin
      page     = page_of(nvm_addr_i);
      glob_blk = ~cfg_q.global_write_protect;
      seg_hit  = 1'b0;
      if (!cfg_q.segment_protect_disable) begin
         if (!cfg_q.segment_boundary_direction)
            seg_hit = page <= cfg_q.segment_page_pointer;
         else
            seg_hit = page >= cfg_q.segment_page_pointer;
         if (!cfg_q.last_page_protect && page == LAST_PAGE)
            seg_hit = 1'b1;
      end
      nvm_block_d = nvm_req_i && (st_q == HOLD) && (glob_blk || seg_hit);
      nvm_grant_d = nvm_req_i && (st_q == HOLD) && !(glob_blk || seg_hit);
      ext_block_d = ext_req_i && (st_q == HOLD) && cfg_q.global_read_protect;
      ext_grant_d = ext_req_i && (st_q == HOLD) && !cfg_q.global_read_protect;
      if (ext_write_i && ext_req_i && (st_q == HOLD) && !cfg_q.global_read_protect && glob_blk) begin
         ext_block_d = 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         nvm_grant_o <= 1'b0;
         nvm_block_o <= 1'b0;
         ext_grant_o <= 1'b0;
         ext_block_o <= 1'b0;
         cfg_valid_o <= 1'b0;
      end else begin
         nvm_grant_o <= nvm_grant_d;
         nvm_block_o <= nvm_block_d;
         ext_grant_o <= ext_grant_d;
         ext_block_o <= ext_block_d;
         cfg_valid_o <= 1'b1;
      end
   end

   // External programmer access depends on the read protect bit alone.
   a_ext_refused: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (ext_req_i && st_q == HOLD && cfg_q.global_read_protect)
      |=> (ext_block_o && !ext_grant_o))
      else $error("External access granted under read protect.");

   a_ext_allowed: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (ext_req_i && st_q == HOLD && !cfg_q.global_read_protect)
      |=> (ext_grant_o && !ext_block_o))
      else $error("External access refused without read protect.");

   a_ext_write_refused: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (ext_req_i && ext_write_i && st_q == HOLD && cfg_q.global_read_protect)
      |=> ext_block_o)
      else $error("External write not refused under read protect.");

   a_ext_answer: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (ext_req_i && st_q == HOLD)
      |=> (ext_grant_o || ext_block_o))
      else $error("External request left without an answer.");

   a_ext_idle: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !ext_req_i
      |=> (!ext_grant_o && !ext_block_o))
      else $error("External answer without a request.");

   // Internal write and erase requests.
   a_glob_write: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && !cfg_q.global_write_protect)
      |=> !nvm_grant_o)
      else $error("Internal write granted under global write protect.");

   a_glob_block: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && !cfg_q.global_write_protect)
      |=> nvm_block_o)
      else $error("Internal write not blocked under global write protect.");

   a_seg_low: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && !cfg_q.segment_protect_disable && !cfg_q.segment_boundary_direction
       && page_of(nvm_addr_i) <= cfg_q.segment_page_pointer)
      |=> !nvm_grant_o)
      else $error("Write granted inside lower segment.");

   a_seg_low_block: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && !cfg_q.segment_protect_disable && !cfg_q.segment_boundary_direction
       && page_of(nvm_addr_i) <= cfg_q.segment_page_pointer)
      |=> nvm_block_o)
      else $error("Write inside lower segment not blocked.");

   // A page just past the lower segment stays writable unless another check covers it.
   a_seg_low_above: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && cfg_q.global_write_protect && !cfg_q.segment_protect_disable
       && !cfg_q.segment_boundary_direction && page_of(nvm_addr_i) > cfg_q.segment_page_pointer
       && (cfg_q.last_page_protect || page_of(nvm_addr_i) != LAST_PAGE))
      |=> nvm_grant_o)
      else $error("Write above lower segment blocked.");

   a_seg_high: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && !cfg_q.segment_protect_disable && cfg_q.segment_boundary_direction
       && page_of(nvm_addr_i) >= cfg_q.segment_page_pointer)
      |=> !nvm_grant_o)
      else $error("Write granted inside upper segment.");

   a_seg_high_block: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && !cfg_q.segment_protect_disable && cfg_q.segment_boundary_direction
       && page_of(nvm_addr_i) >= cfg_q.segment_page_pointer)
      |=> nvm_block_o)
      else $error("Write inside upper segment not blocked.");

   a_seg_high_below: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && cfg_q.global_write_protect && !cfg_q.segment_protect_disable
       && cfg_q.segment_boundary_direction && page_of(nvm_addr_i) < cfg_q.segment_page_pointer
       && (cfg_q.last_page_protect || page_of(nvm_addr_i) != LAST_PAGE))
      |=> nvm_grant_o)
      else $error("Write below upper segment blocked.");

   a_last_page: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && !cfg_q.segment_protect_disable && !cfg_q.last_page_protect
       && page_of(nvm_addr_i) == LAST_PAGE)
      |=> nvm_block_o)
      else $error("Last page not protected.");

   a_seg_off: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && cfg_q.segment_protect_disable && cfg_q.global_write_protect)
      |=> nvm_grant_o)
      else $error("Write blocked with segment disabled.");

   // Disabling the segment must never lift the global block.
   a_seg_off_global: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD && cfg_q.segment_protect_disable && !cfg_q.global_write_protect)
      |=> nvm_block_o)
      else $error("Global block lost with segment disabled.");

   a_nvm_answer: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (nvm_req_i && st_q == HOLD)
      |=> (nvm_grant_o || nvm_block_o))
      else $error("Internal request left without an answer.");

   a_nvm_idle: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !nvm_req_i
      |=> (!nvm_grant_o && !nvm_block_o))
      else $error("Internal answer without a request.");

   // Settings and start-up behaviour.
   a_cfg_stable: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (st_q == HOLD)
      |=> $stable(cfg_q))
      else $error("Settings changed outside reset.");

   a_refuse_capture: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (st_q == CAPTURE)
      |=> (!nvm_grant_o && !nvm_block_o && !ext_grant_o && !ext_block_o))
      else $error("Answer given in the first cycle after reset.");

   a_cfg_valid_on: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (st_q == HOLD)
      |-> cfg_valid_o)
      else $error("Settings valid flag low while holding.");

   a_cfg_valid_off: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      (st_q == CAPTURE)
      |-> !cfg_valid_o)
      else $error("Settings valid flag high before capture ended.");

   // Grant and block exclude each other on both request paths.
   a_one_answer: assert property (
      @(posedge mclk_i) disable iff (rst_i)
      !(nvm_grant_o && nvm_block_o) && !(ext_grant_o && ext_block_o))
      else $error("Grant and block together.");

endmodule

// File: verification/pm_partner.sv
// Model of the flash sequencer and external programmer that raise requests.
module pm_partner (
   // Clock.
   input  wire logic        mclk_i,
   // Requests towards the protection block.
   output logic             nvm_req_o,
   output logic [23:0]      nvm_addr_o,
   output logic             ext_req_o,
   output logic             ext_write_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      nvm_req_o = 1'b0;
      nvm_addr_o = 24'h0;
      ext_req_o = 1'b0;
      ext_write_o = 1'b0;
   end
   // Called just after a falling edge, so the request holds through the next rising edge.
   task automatic issue(input logic [23:0] addr, input logic wr);
      nvm_req_o = 1'b1;
      nvm_addr_o = addr;
      ext_req_o = 1'b1;
      ext_write_o = wr;
   endtask
   // A released address shows its inverse, so a stale value can never pass by accident.
   task automatic idle();
      nvm_req_o = 1'b0;
      nvm_addr_o = ~nvm_addr_o;
      ext_req_o = 1'b0;
   endtask
endmodule

// File: verification/program_memory_write_protection_tb_top.sv
// Self-checking bench for the program memory protection block.
module program_memory_write_protection_tb_top;
   import pm_protect_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] LP = 8'h55;
   logic       mclk_i = 1'b0;
   logic       rst_i = 1'b1;
   prot_cfg_t  cfg_i = '0;
   prot_cfg_t  cfg_q;
   logic       nreq, ereq, ewr, ngnt, nblk, egnt, eblk, cvld, b;
   logic [23:0] addr, a;
   logic [13:0] pg;
   int         errors = 0;
   int         n_compared = 0;
   always #50 mclk_i = ~mclk_i;
   pm_partner i_pm_partner (.mclk_i(mclk_i), .nvm_req_o(nreq), .nvm_addr_o(addr), .ext_req_o(ereq),
      .ext_write_o(ewr));
   pm_protect #(.LAST_PAGE(LP)) i_pm_protect (.mclk_i(mclk_i), .rst_i(rst_i), .cfg_i(cfg_i), .nvm_req_i(nreq),
      .nvm_addr_i(addr), .ext_req_i(ereq), .ext_write_i(ewr), .nvm_grant_o(ngnt), .nvm_block_o(nblk),
      .ext_grant_o(egnt), .ext_block_o(eblk), .cfg_valid_o(cvld));
   // Pages past the last implemented page fold onto it.
   function automatic logic blk(prot_cfg_t c, logic [23:0] x);
      logic [7:0] p;
      p = (x[23:10] > {6'h0, LP}) ? LP : x[17:10];
      return !c.global_write_protect || (!c.segment_protect_disable && ((c.segment_boundary_direction ?
         p >= c.segment_page_pointer : p <= c.segment_page_pointer) || (!c.last_page_protect && p == LP)));
   endfunction
   task automatic chk(input string n, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic end_of_test();
      if (errors == 0 && n_compared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      void'($urandom(67265));
      for (int t = 0; t < 40; t++) begin
         cfg_q = prot_cfg_t'($urandom);
         cfg_q[12:8] = t[4:0];
         @(negedge mclk_i);
         rst_i = 1'b1;
         cfg_i = cfg_q;
         repeat (3) @(negedge mclk_i);
         rst_i = 1'b0;
         cfg_i = ~cfg_q;
         i_pm_partner.issue({6'h0, cfg_q.segment_page_pointer, 10'h0}, 1'b1);
         @(negedge mclk_i);
         chk("cfg_valid", 1'b1, cvld);
         chk("nvm_grant_first", 1'b0, ngnt);
         chk("nvm_block_first", 1'b0, nblk);
         chk("ext_first", 1'b0, egnt | eblk);
         for (int k = 0; k < 14; k++) begin
            pg = (k < 3) ? 14'({6'h0, cfg_q.segment_page_pointer} + 14'(k) - 14'h1) :
                 (k < 5) ? 14'({6'h0, LP} + 14'(k - 3)) : 14'($urandom_range(0, 8'h60));
            a = {pg, 10'($urandom)};
            b = blk(cfg_q, a);
            i_pm_partner.issue(a, 1'($urandom));
            @(negedge mclk_i);
            chk("nvm_block", b, nblk);
            chk("nvm_grant", !b, ngnt);
            chk("ext_block", cfg_q.global_read_protect, eblk);
            chk("ext_grant", !cfg_q.global_read_protect, egnt);
         end
         i_pm_partner.idle();
         @(negedge mclk_i);
         chk("nvm_idle", 1'b0, ngnt | nblk);
         chk("ext_idle", 1'b0, egnt | eblk);
      end
      end_of_test();
   end
endmodule
